/* File: rtl/btc_exec.sv */
// Execution unit for bit-test, compare, skip, decimal adjust, int hold.
// Assumes decode presents one operation per cycle with op_valid, operands
// already read, and that fetch reports the size of the next instruction.
`timescale 1ns/100ps
`default_nettype none
`include "btc_regs.svh"
module btc_exec
    import btc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  var  btc_op_t     op_code,
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic        lit_sel,
    input  wire logic [4:0]  short_literal,
    input  wire logic [3:0]  bit_select_literal,
    input  wire logic        bit_from_reg,
    input  wire logic        flag_to_carry,
    input  wire logic        file_form,
    input  wire logic [13:0] cycle_count_literal,
    input  wire logic        next_two_word,
    input  wire logic [15:0] status_in,
    output logic             busy,
    output logic             skip_active,
    output logic [15:0]      status_out,
    output logic             status_we,
    output logic [15:0]      result,
    output logic             result_we,
    output logic             int_block
);
    btc_alu_if alu_bus ();
    btc_alu btc_alu_i (.bus(alu_bus));

    btc_state_t  state_r;
    logic [3:0]  bsel;
    logic        tbit;
    logic        take;
    logic [15:0] opb_eff;
    logic        go;
    logic [13:0] hold_r;
    logic        c_in;

    assign go   = op_valid && state_r == BTC_ST_RUN;
    assign c_in = status_in[`BTC_SR_C];
    assign bsel = bit_from_reg ? op_b[3:0] : bit_select_literal;
    assign tbit = op_a[bsel];

    // Second operand: literal, zero or register
    always_comb begin
        opb_eff = op_b;
        if (op_code == BTC_OP_CMP0) begin
            opb_eff = `BTC_ZERO;
        end else if (lit_sel) begin
            opb_eff = {11'h000, short_literal};
        end
    end
    assign alu_bus.opa = op_a;
    assign alu_bus.opb = opb_eff;
    // Plain compare forces carry-in so no borrow applies
    assign alu_bus.cin = (op_code == BTC_OP_CMPB || op_code == BTC_OP_DAW)
                       ? c_in : 1'b1;
    assign alu_bus.decimal_adjust_op = (op_code == BTC_OP_DAW);

    // Skip decision; greater/less are signed comparisons
    always_comb begin
        unique case (op_code)
            BTC_OP_TSC: take = !tbit;
            BTC_OP_TSS: take = tbit;
            BTC_OP_SEQ: take = (op_a == op_b);
            BTC_OP_SGT: take = ($signed(op_a) > $signed(op_b));
            BTC_OP_SLT: take = ($signed(op_a) < $signed(op_b));
            BTC_OP_SNE: take = (op_a != op_b);
            default:    take = 1'b0;
        endcase
    end

    // Skip sequencer: discarded words occupy extra cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= BTC_ST_RUN;
        end else begin
            unique case (state_r)
                BTC_ST_RUN: begin
                    if (go && take) begin
                        state_r <= next_two_word ? BTC_ST_SKIP2
                                                 : BTC_ST_SKIP1;
                    end
                end
                BTC_ST_SKIP2: state_r <= BTC_ST_SKIP1;
                BTC_ST_SKIP1: state_r <= BTC_ST_RUN;
                default:      state_r <= BTC_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy        <= 1'b0;
            skip_active <= 1'b0;
        end else begin
            busy        <= (go && take) || state_r == BTC_ST_SKIP2;
            skip_active <= (go && take) || state_r == BTC_ST_SKIP2;
        end
    end

    // Status update; only the flags each operation owns are touched
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_out <= 16'h0000;
            status_we  <= 1'b0;
        end else begin
            status_out <= status_in;
            status_we  <= 1'b0;
            if (go) begin
                unique case (op_code)
                    BTC_OP_TST, BTC_OP_TSTS: begin
                        status_we <= 1'b1;
                        if (flag_to_carry && !file_form) begin
                            status_out[`BTC_SR_C] <= tbit;
                        end else begin
                            status_out[`BTC_SR_Z] <= !tbit;
                        end
                    end
                    BTC_OP_CMP, BTC_OP_CMP0, BTC_OP_CMPB: begin
                        status_we <= 1'b1;
                        status_out[`BTC_SR_C]  <= alu_bus.c;
                        status_out[`BTC_SR_DC] <= alu_bus.dc;
                        status_out[`BTC_SR_N]  <= alu_bus.n;
                        status_out[`BTC_SR_OV] <= alu_bus.ov;
                        // Borrow form keeps Z sticky for multi-word chains
                        status_out[`BTC_SR_Z] <= (op_code == BTC_OP_CMPB)
                            ? (alu_bus.z & status_in[`BTC_SR_Z])
                            : alu_bus.z;
                    end
                    BTC_OP_DAW: begin
                        status_we <= 1'b1;
                        status_out[`BTC_SR_C] <= alu_bus.c;
                    end
                    default: status_we <= 1'b0;
                endcase
            end
        end
    end

    // Register write-back: set-after-test and decimal adjust only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result    <= 16'h0000;
            result_we <= 1'b0;
        end else begin
            result    <= op_a;
            result_we <= 1'b0;
            if (go && op_code == BTC_OP_TSTS) begin
                result    <= op_a | (16'h0001 << bsel);
                result_we <= 1'b1;
            end else if (go && op_code == BTC_OP_DAW) begin
                result    <= alu_bus.res;
                result_we <= 1'b1;
            end
        end
    end

    // Interrupt hold counter, decremented once per cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hold_r    <= 14'h0000;
            int_block <= 1'b0;
        end else if (go && op_code == BTC_OP_HOLD) begin
            hold_r    <= cycle_count_literal;
            int_block <= (cycle_count_literal != 14'h0000);
        end else begin
            if (hold_r != 14'h0000) begin
                hold_r <= hold_r - 14'h0001;
            end
            int_block <= (hold_r > 14'h0001);
        end
    end

    // Steps of the counted-length behaviours checked below
    sequence s_skip_once;
        skip_active ##1 !skip_active;
    endsequence
    sequence s_skip_twice;
        skip_active [*2] ##1 !skip_active;
    endsequence
    sequence s_block_thrice;
        int_block [*3] ##1 !int_block;
    endsequence

    a_skip_one_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && take && !next_two_word |=> s_skip_once)
        else $error("One-word skip not two cycles");
    a_skip_two_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && take && next_two_word |=> s_skip_twice)
        else $error("Two-word skip not three cycles");
    a_noskip_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_TSC && tbit |=> !skip_active)
        else $error("Skip on set bit");
    a_skip_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_TSS && tbit |=> skip_active)
        else $error("No skip on set bit");
    a_skip_equal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_SEQ && op_a == op_b |=> skip_active)
        else $error("Equal skip missed");
    a_skip_noflags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code inside {BTC_OP_SGT, BTC_OP_SLT, BTC_OP_SNE}
        |=> !status_we)
        else $error("Skip compare wrote flags");
    a_carry_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_TST && flag_to_carry && !file_form
        |=> status_out[`BTC_SR_C] == $past(tbit))
        else $error("Carry not tested bit");
    a_set_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_TSTS |=> result_we && result[$past(bsel)])
        else $error("Bit not set");
    a_cmp0_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_CMP0 && op_a == `BTC_ZERO
        |=> status_out[`BTC_SR_Z] && status_out[`BTC_SR_C])
        else $error("Zero compare flags wrong");
    a_hold_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op_code == BTC_OP_HOLD && cycle_count_literal == 14'h0003
        |=> s_block_thrice)
        else $error("Hold length wrong");
endmodule
`default_nettype wire

/* File: rtl/btc_regs.svh */
// Constants for the bit-test / compare execution slice.
// Assumes inclusion by the package, the design modules and the bench.
// Functional notes
// - Skip-if-clear tests a 4-bit-selected bit of a file or work register and skips when it is zero, taking 1 cycle or 2/3 when skipping, no flags.
// - Skip-if-set tests the selected bit and skips when it is one, 1 cycle or 2/3 when skipping, no flags.
// - Bit test to carry copies the selected work-register bit, chosen by literal or register, into carry in one cycle.
// - Bit test to zero sets zero from the selected bit (Z = inverted bit), only zero changes, one cycle.
// - Test-then-set records the bit into carry or zero (zero only for file form), then writes the bit to one, one cycle.
// - Compare subtracts second from first without storing and updates C, DC, N, OV, Z in one cycle.
// - Compare also takes an unsigned 5-bit literal subtrahend, with the same flags.
// - Compare with borrow evaluates a - b - !C and updates C, DC, N, OV, Z without storing.
// - Compare to zero compares a register with 0x0000 and updates C, DC, N, OV, Z.
// - Compare-skip-equal skips when the two work registers are equal, no flags.
// - Compare-skip-greater skips when the first (signed) exceeds the second, no flags.
// - Compare-skip-less skips when the first (signed) is below the second, no flags.
// - Compare-skip-not-equal skips when the two differ, no flags.
// - Decimal adjust corrects a work register after packed-BCD add and changes only carry.
// - Interrupt hold blocks interrupts for a 14-bit literal count of following cycles, no flags.
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH
`define BTC_DW        16
`define BTC_SR_C      0
`define BTC_SR_Z      1
`define BTC_SR_OV     2
`define BTC_SR_N      3
`define BTC_SR_DC     8
`define BTC_DC_BIT    8
`define BTC_ZERO      16'h0000
`define BTC_HOLD_W    14
`define BTC_SHORT_LITERAL_W    5
`define BTC_SKIP1_CYC 2'h2
`define BTC_SKIP2_CYC 2'h3
`endif

/* File: rtl/btc_pkg.sv */
// Types for the bit-test / compare execution slice.
// Assumes btc_regs.svh is on the include path.
`include "btc_regs.svh"
package btc_pkg;
    typedef enum logic [3:0] {
        BTC_OP_NONE     = 4'h0,
        BTC_OP_TSC      = 4'h1,  // bit_test_skip_clear
        BTC_OP_TSS      = 4'h2,  // bit_test_skip_set
        BTC_OP_TST      = 4'h3,  // bit_test_to_flag
        BTC_OP_TSTS     = 4'h4,  // bit_test_then_set
        BTC_OP_CMP      = 4'h5,  // compare_op
        BTC_OP_CMP0     = 4'h6,  // compare_zero_op
        BTC_OP_CMPB     = 4'h7,  // compare_borrow_op
        BTC_OP_SEQ      = 4'h8,  // compare_skip_equal
        BTC_OP_SGT      = 4'h9,  // compare_skip_greater
        BTC_OP_SLT      = 4'ha,  // compare_skip_less
        BTC_OP_SNE      = 4'hb,  // compare_skip_not_equal
        BTC_OP_DAW      = 4'hc,  // decimal_adjust_op
        BTC_OP_HOLD     = 4'hd   // interrupt_hold_op
    } btc_op_t;
    typedef enum logic [2:0] {
        BTC_ST_RUN   = 3'b001,
        BTC_ST_SKIP1 = 3'b010,
        BTC_ST_SKIP2 = 3'b100
    } btc_state_t;
endpackage

/* File: rtl/btc_alu_if.sv */
// Carrier between the execution unit and its compare/adjust datapath.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface btc_alu_if;
    logic [15:0] opa;
    logic [15:0] opb;
    logic        cin;
    logic        decimal_adjust_op;
    logic [15:0] res;
    logic        c;
    logic        dc;
    logic        n;
    logic        ov;
    logic        z;
    modport exec (output opa, opb, cin, decimal_adjust_op, input res, c, dc, n, ov, z);
    modport alu  (input opa, opb, cin, decimal_adjust_op, output res, c, dc, n, ov, z);
endinterface
`default_nettype wire

/* File: rtl/btc_alu.sv */
// Combinational subtract-with-carry and decimal-adjust datapath.
// Assumes operands are held stable by the execution unit for one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "btc_regs.svh"
module btc_alu
    import btc_pkg::*;
(
    btc_alu_if.alu bus
);
    logic [16:0] diff;
    logic [8:0]  lo;
    logic [15:0] adj;
    logic        adj_c;
    // Subtract as a + ~b + cin so borrow maps onto carry
    assign diff = {1'b0, bus.opa} + {1'b0, ~bus.opb} + {16'h0000, bus.cin};
    // Digit carry is the carry out of the low byte on word operands
    assign lo = {1'b0, bus.opa[7:0]} + {1'b0, ~bus.opb[7:0]}
              + {8'h00, bus.cin};
    // Byte-wide BCD adjust; carry can only be set, never cleared
    always_comb begin
        adj   = bus.opa;
        adj_c = bus.cin;
        if (adj[3:0] > 4'h9) begin
            adj[7:0] = adj[7:0] + 8'h06;
        end
        if (adj[7:4] > 4'h9 || bus.cin) begin
            {adj_c, adj[7:4]} = {1'b0, adj[7:4]} + 5'h06;
            adj_c = adj_c | bus.cin;
        end
    end
    assign bus.res = bus.decimal_adjust_op ? adj : diff[15:0];
    assign bus.c   = bus.decimal_adjust_op ? adj_c : diff[16];
    assign bus.dc  = lo[`BTC_DC_BIT];
    assign bus.n   = diff[15];
    assign bus.ov  = (bus.opa[15] ^ bus.opb[15]) & (bus.opa[15] ^ diff[15]);
    assign bus.z   = (diff[15:0] == `BTC_ZERO);
endmodule
`default_nettype wire

/* File: tb/bit_test_compare_instr_subset_test.sv */
// Self-checking bench for the bit-test / compare execution unit.
// Assumes btc_pkg and btc_regs.svh are compiled ahead of this file.
`timescale 1ns/100ps
`default_nettype none
`include "btc_regs.svh"
module bit_test_compare_instr_subset_test
    import btc_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    btc_op_t     op_code = BTC_OP_NONE;
    logic [15:0] op_a = 16'h0000;
    logic [15:0] op_b = 16'h0000;
    logic        lit_sel = 1'b0;
    logic [4:0]  short_literal = 5'h00;
    logic [3:0]  bit_select_literal = 4'h0;
    logic        bit_from_reg = 1'b0;
    logic        flag_to_carry = 1'b0;
    logic        file_form = 1'b0;
    logic [13:0] cycle_count_literal = 14'h0000;
    logic        next_two_word = 1'b0;
    logic [15:0] status_in = 16'h0000;
    logic        busy;
    logic        skip_active;
    logic [15:0] status_out;
    logic        status_we;
    logic [15:0] result;
    logic        result_we;
    logic        int_block;
    int          err_total = 0;
    int          num_checks = 0;
    int          cycles = 0;

    btc_exec btc_exec_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
        .lit_sel(lit_sel), .short_literal(short_literal),
        .bit_select_literal(bit_select_literal),
        .bit_from_reg(bit_from_reg), .flag_to_carry(flag_to_carry),
        .file_form(file_form), .cycle_count_literal(cycle_count_literal),
        .next_two_word(next_two_word), .status_in(status_in),
        .busy(busy), .skip_active(skip_active), .status_out(status_out),
        .status_we(status_we), .result(result), .result_we(result_we),
        .int_block(int_block));

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 50 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected status after a - b - !cin; other bits pass through
    function automatic logic [15:0] cmp_sr(input logic [15:0] a, b, sr,
                                           input logic cin, sticky);
        logic [16:0] s;
        logic [8:0]  lo;
        logic [15:0] r;
        s = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
        lo = {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + {8'h00, cin};
        r = sr;
        r[`BTC_SR_C] = s[16];
        r[`BTC_SR_DC] = lo[8];
        r[`BTC_SR_N] = s[15];
        r[`BTC_SR_OV] = (a[15] ^ b[15]) & (a[15] ^ s[15]);
        r[`BTC_SR_Z] = (s[15:0] == 16'h0000) & (~sticky | sr[`BTC_SR_Z]);
        return r;
    endfunction

    // Present one op just after an edge; return just after the taking edge.
    // Valid stays up, so a following op needs no idle cycle in between.
    task automatic go(input btc_op_t op, input logic [15:0] a, b);
        op_code = op;
        op_a = a;
        op_b = b;
        op_valid = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic cmp_case(input btc_op_t op, input logic [15:0] a, b,
                            input logic cin, sticky);
        go(op, a, b);
        check(status_we, 1'b1);
        check(status_out, cmp_sr(a, b, status_in, cin, sticky));
        check(result_we, 1'b0);
    endtask

    task automatic t_compare();
        status_in = 16'h4002;
        cmp_case(BTC_OP_CMP, 16'h8000, 16'h0001, 1'b1, 1'b0);
        lit_sel = 1'b1;
        short_literal = 5'h1f;
        go(BTC_OP_CMP, 16'h001f, 16'h1234);
        check(status_out, cmp_sr(16'h001f, 16'h001f, 16'h4002, 1, 0));
        lit_sel = 1'b0;
        status_in = 16'h0002;
        cmp_case(BTC_OP_CMPB, 16'h0005, 16'h0004, 1'b0, 1'b1);
        status_in = 16'h0001;
        cmp_case(BTC_OP_CMPB, 16'h0005, 16'h0005, 1'b1, 1'b1);
        cmp_case(BTC_OP_CMP0, 16'h8000, 16'h0000, 1'b1, 1'b0);
        status_in = 16'h0000;
        cmp_case(BTC_OP_CMP, 16'h0010, 16'h0001, 1'b1, 1'b0);
    endtask

    task automatic t_bits();
        status_in = 16'h0000;
        bit_select_literal = 4'hf;
        flag_to_carry = 1'b1;
        go(BTC_OP_TST, 16'h8000, 16'h0000);
        check(status_out, 16'h0001);
        check(status_we, 1'b1);
        status_in = 16'h0002;
        flag_to_carry = 1'b0;
        go(BTC_OP_TST, 16'h8000, 16'h0000);
        check(status_out, 16'h0000);
        status_in = 16'h0000;
        bit_from_reg = 1'b1;
        file_form = 1'b1;
        flag_to_carry = 1'b1;
        go(BTC_OP_TST, 16'hfff7, 16'h0003);
        check(status_out, 16'h0002);
        bit_from_reg = 1'b0;
        file_form = 1'b0;
        bit_select_literal = 4'h4;
        status_in = 16'h0001;
        go(BTC_OP_TSTS, 16'h0100, 16'h0000);
        check(status_out, 16'h0000);
        check(result, 16'h0110);
        check(result_we, 1'b1);
        file_form = 1'b1;
        go(BTC_OP_TSTS, 16'h0000, 16'h0000);
        check(status_out, 16'h0003);
        check(result, 16'h0010);
        file_form = 1'b0;
    endtask

    // Valid stays up through the discarded cycles, where the op (a compare on two-word skips) is refused
    task automatic skip_case(input btc_op_t op, input logic [15:0] a, b,
                             input logic two, exp);
        next_two_word = two;
        go(op, a, b);
        check(skip_active, exp);
        check(busy, exp);
        check(status_we, 1'b0);
        if (exp && two) begin
            status_in = 16'h0000;
            op_code = BTC_OP_CMP;
            op_valid = 1'b1;
            @(posedge sys_clk);
            #1;
            check(skip_active, 1'b1);
            check(status_we, 1'b0);
        end
        @(posedge sys_clk);
        #1;
        check(skip_active, 1'b0);
        check(status_we, 1'b0);
    endtask

    task automatic t_skip();
        bit_select_literal = 4'h2;
        skip_case(BTC_OP_TSC, 16'hfffb, 16'h0000, 1'b0, 1'b1);
        skip_case(BTC_OP_TSC, 16'h0004, 16'h0000, 1'b1, 1'b0);
        skip_case(BTC_OP_TSS, 16'h0004, 16'h0000, 1'b1, 1'b1);
        skip_case(BTC_OP_TSS, 16'hfffb, 16'h0000, 1'b0, 1'b0);
        skip_case(BTC_OP_SEQ, 16'h1234, 16'h1234, 1'b0, 1'b1);
        skip_case(BTC_OP_SEQ, 16'h1234, 16'h1235, 1'b0, 1'b0);
        skip_case(BTC_OP_SGT, 16'h0001, 16'hffff, 1'b1, 1'b1);
        skip_case(BTC_OP_SGT, 16'hffff, 16'h0001, 1'b0, 1'b0);
        skip_case(BTC_OP_SLT, 16'hffff, 16'h0001, 1'b0, 1'b1);
        skip_case(BTC_OP_SLT, 16'h0001, 16'h0001, 1'b0, 1'b0);
        skip_case(BTC_OP_SNE, 16'h0001, 16'h0002, 1'b1, 1'b1);
        skip_case(BTC_OP_SNE, 16'h0002, 16'h0002, 1'b0, 1'b0);
    endtask

    task automatic t_daw_hold();
        status_in = 16'h0000;
        go(BTC_OP_DAW, 16'h009a, 16'h0000);
        check(result, 16'h0000);
        check(status_out, 16'h0001);
        status_in = 16'h0001;
        go(BTC_OP_DAW, 16'h0012, 16'h0000);
        check(result, 16'h0072);
        check(result_we, 1'b1);
        cycle_count_literal = 14'h0003;
        go(BTC_OP_HOLD, 16'h0000, 16'h0000);
        check(status_we, 1'b0);
        op_valid = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            check(int_block, (i <= 3));
            @(posedge sys_clk);
            #1;
        end
        cycle_count_literal = 14'h0000;
        go(BTC_OP_HOLD, 16'h0000, 16'h0000);
        check(int_block, 1'b0);
    endtask

    // Reset held five cycles, released just after an edge
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        check(status_we, 1'b0);
        check(int_block, 1'b0);
        rst_n = 1'b1;
        t_compare();
        t_bits();
        t_skip();
        t_daw_hold();
        report_and_stop();
    end
endmodule
`default_nettype wire
